// ===== hw/isb_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and registered flags.
  Assumes a synchronous clear that drops all contents in one cycle.
*/
`timescale 1ns/100ps
module isb_fifo
  import isb_pkg::*;
#(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   clr,
  input  wire logic                   wr_valid,
  output logic                        wr_ready,
  input  wire logic [W-1:0]           wr_data,
  output logic                        rd_valid,
  input  wire logic                   rd_ready,
  output logic [W-1:0]                rd_data,
  output logic [$clog2(D):0]          count
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_d;
  logic          do_wr;
  logic          do_rd;

  assign do_wr   = wr_valid && wr_ready;
  assign do_rd   = rd_valid && rd_ready;
  assign rd_data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count;
    if (do_wr && !do_rd) begin
      count_d = count + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      count_d = count - (AW+1)'(1);
    end
    if (clr) begin
      count_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  // Flags come from flops so that the ready seen by the source is glitch-free.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count    <= '0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      if (clr) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
      end else begin
        if (do_wr) begin
          wr_ptr_q <= wr_ptr_q + AW'(1);
        end
        if (do_rd) begin
          rd_ptr_q <= rd_ptr_q + AW'(1);
        end
      end
      count    <= count_d;
      wr_ready <= count_d != (AW+1)'(D);
      rd_valid <= count_d != '0;
    end
  end
endmodule

// ===== hw/isb_lat_timer.sv
/*
  Latency timer: pulses once when data has waited CYCLES clocks.
  Assumes restart pulses on every new byte and active while data waits.
*/
`timescale 1ns/100ps
module isb_lat_timer
  import isb_pkg::*;
#(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic restart,
  input  wire logic active,
  output logic      expire
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart || !active) begin
        cnt_q <= '0;
      end else if (cnt_q == 32'(CYCLES - 1)) begin
        cnt_q  <= '0;
        expire <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule

// ===== hw/isb_pkg.sv
/*
  Shared constants and types of the two-wire slave data bridge.
  Assumes a single 100 MHz system clock and no software-visible registers.
*/
package isb_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned LAT_TIME_MS  = 16;
  localparam int unsigned LAT_CYCLES   = (CLK_HZ / 1000) * LAT_TIME_MS;

  localparam int unsigned BUF_WIDTH    = 8;
  localparam int unsigned BUF_DEPTH    = 16;

  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  TX_BITS      = 4'h8;
  localparam logic [3:0]  MACK_OK      = 4'h1;

  localparam logic [7:0]  GEN_CALL     = 8'h00;
  localparam logic [7:0]  GC_SOFT_RST  = 8'h06;
  localparam logic [7:0]  GC_AVAIL     = 8'h0C;
  localparam logic [7:0]  GC_FLUSH     = 8'h0E;
  localparam logic [4:0]  TEN_BIT_HDR  = 5'h1E;
  localparam logic [7:0]  IDLE_BYTE    = 8'hFF;
  localparam logic [7:0]  AVAIL_SAT    = 8'hFF;

  typedef struct packed {
    logic       ten_bit;
    logic [9:0] addr;
    logic       serial_layer_en;
  } isb_cfg_t;

  localparam isb_cfg_t CFG_RESET = '{ten_bit: 1'b0, addr: 10'h022, serial_layer_en: 1'b0};

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } isb_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR2,
    ST_WRITE,
    ST_GCMD,
    ST_ACK,
    ST_READ,
    ST_MACK,
    ST_IGNORE
  } isb_state_t;

endpackage

// ===== hw/isb_top.sv
/*
  Two-wire slave data bridge between an external bus master and a USB host
  byte stream, with address decode, general call commands and buffering.
  Assumes SCL and SDA inputs are already synchronous to SYS_CLK and far
  slower than it, and that the host stream follows valid/ready.
*/
`timescale 1ns/100ps
// Functional notes
// - Slave only; SCL is an input and all bit timing follows it.
// - Host bytes enter the outgoing buffer and leave through slave reads.
// - Master-written bytes are stored in arrival order for the host.
// - Incoming bytes go to the host when full or latency timer expires.
// - Slave address comes from the config store, rewritable from the host.
// - Data transfers are accepted only at the configured slave address.
// - Both 7-bit and 10-bit address forms are decoded.
// - 7-bit first byte is address then direction; 1 means read.
// - General call address is acknowledged and its next byte is a command.
// - The standard software reset command is implemented with custom ones.
// - Serial-port settings such as baud rate do not affect transfers.
// - A stored option bit tells the host whether to load the serial layer.
// - That option bit is cleared, serial layer disabled, after reset.
// - A read with an empty outgoing buffer gets no address acknowledge unless a 0x0C count query is pending.
// - Writes are refused at address or data byte when there is no room.
// - Command 0x06 resets and clears buffers; 0x0E flushes both buffers.
// - After command 0x0C the next read returns the saturated byte count.
module isb_top
  import isb_pkg::*;
#(
  parameter int unsigned LATENCY_CYCLES = LAT_CYCLES
) (
  input  wire logic       SYS_CLK,
  input  wire logic       ARST_N,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  input  wire logic [7:0] HOST_TX_DATA,
  input  wire logic       HOST_TX_VALID,
  output logic            HOST_TX_READY,
  output logic [7:0]      HOST_RX_DATA,
  output logic            HOST_RX_VALID,
  input  wire logic       HOST_RX_READY,
  input  wire logic       CFG_WE,
  input  wire logic       CFG_TEN_BIT,
  input  wire logic [9:0] CFG_ADDR,
  input  wire logic       CFG_SERIAL_EN,
  output logic            SERIAL_LAYER_EN,
  output logic            TX_EMPTY_N,
  output logic            RX_FULL_N
);

  logic        rst_s1_q;
  logic        rst_n;
  isb_cfg_t    cfg_q;
  logic        scl_q;
  logic        scl_p_q;
  logic        sda_q;
  logic        sda_p_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  isb_state_t  state_q;
  isb_state_t  nxt_q;
  isb_state_t  nxt_d;
  logic [7:0]  shift_q;
  logic [7:0]  byte_in;
  logic [7:0]  tx_sh_q;
  logic [3:0]  cnt_q;
  logic        ack_q;
  logic        ack_d;
  logic        ack_drv_q;
  logic        push_d;
  logic        match10_q;
  logic        query_q;
  logic        flush_q;
  logic        tx_pop_q;
  isb_byte_t   rx_wr_q;
  logic        fwd_q;
  logic        lat_expire;
  logic [7:0]  avail;
  logic [7:0]  load_byte;
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic [4:0]  tx_count;
  logic        rx_room;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_pop;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // The store keeps its value across a bus soft reset, as non-volatile memory would.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (CFG_WE) begin
      cfg_q <= '{ten_bit: CFG_TEN_BIT, addr: CFG_ADDR, serial_layer_en: CFG_SERIAL_EN};
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SERIAL_LAYER_EN <= 1'b0;
      TX_EMPTY_N      <= 1'b0;
      RX_FULL_N       <= 1'b0;
    end else begin
      SERIAL_LAYER_EN <= cfg_q.serial_layer_en;
      TX_EMPTY_N      <= tx_valid;
      RX_FULL_N       <= rx_room;
    end
  end

  // SCL is only ever sampled, never driven.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_q   <= 1'b1;
      scl_p_q <= 1'b1;
      sda_q   <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_q   <= SCL_I;
      scl_p_q <= scl_q;
      sda_q   <= SDA_I;
      sda_p_q <= sda_q;
    end
  end

  assign scl_rise  = scl_q && !scl_p_q;
  assign scl_fall  = !scl_q && scl_p_q;
  assign start_det = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop_det  = scl_q && scl_p_q && !sda_p_q && sda_q;
  assign byte_in   = {shift_q[6:0], sda_q};
  assign SDA_O     = 1'b0;

  always_comb begin
    logic [15:0] wide;
    wide  = 16'(tx_count);
    avail = (wide >= 16'(AVAIL_SAT)) ? AVAIL_SAT : wide[7:0];
    if (query_q) begin
      load_byte = avail;
    end else if (tx_valid) begin
      load_byte = tx_data;
    end else begin
      load_byte = IDLE_BYTE;
    end
  end

  always_comb begin
    ack_d  = 1'b0;
    nxt_d  = ST_IGNORE;
    push_d = 1'b0;
    case (state_q)
      ST_ADDR: begin
        if (byte_in == GEN_CALL) begin
          ack_d = 1'b1;
          nxt_d = ST_GCMD;
        end else if (cfg_q.ten_bit && byte_in[7:3] == TEN_BIT_HDR
                     && byte_in[2:1] == cfg_q.addr[9:8]) begin
          if (!byte_in[0]) begin
            ack_d = 1'b1;
            nxt_d = ST_ADDR2;
          end else if (match10_q) begin
            ack_d = tx_valid || query_q;
            nxt_d = ST_READ;
          end
        end else if (!cfg_q.ten_bit && byte_in[7:1] == cfg_q.addr[6:0]) begin
          if (byte_in[0]) begin
            ack_d = tx_valid || query_q;
            nxt_d = ST_READ;
          end else begin
            ack_d = rx_room;
            nxt_d = ST_WRITE;
          end
        end
      end
      ST_ADDR2: begin
        if (byte_in == cfg_q.addr[7:0]) begin
          ack_d = rx_room;
          nxt_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        ack_d  = rx_room;
        push_d = rx_room;
        nxt_d  = ST_WRITE;
      end
      ST_GCMD: begin
        ack_d = 1'b1;
      end
      default: begin
        ack_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      nxt_q     <= ST_IDLE;
      shift_q   <= '0;
      tx_sh_q   <= '0;
      cnt_q     <= '0;
      ack_q     <= 1'b0;
      ack_drv_q <= 1'b0;
      SDA_OE    <= 1'b0;
      match10_q <= 1'b0;
      query_q   <= 1'b0;
      flush_q   <= 1'b0;
      tx_pop_q  <= 1'b0;
      rx_wr_q   <= '0;
    end else begin
      flush_q       <= 1'b0;
      tx_pop_q      <= 1'b0;
      rx_wr_q.valid <= 1'b0;
      if (start_det) begin
        state_q   <= ST_ADDR;
        cnt_q     <= '0;
        ack_drv_q <= 1'b0;
        SDA_OE    <= 1'b0;
      end else if (stop_det) begin
        state_q   <= ST_IDLE;
        match10_q <= 1'b0;
        ack_drv_q <= 1'b0;
        SDA_OE    <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_ADDR2, ST_WRITE, ST_GCMD: begin
            if (scl_rise) begin
              shift_q <= byte_in;
              cnt_q   <= cnt_q + 4'h1;
              if (cnt_q[2:0] == BIT_LAST) begin
                cnt_q   <= '0;
                ack_q   <= ack_d;
                nxt_q   <= nxt_d;
                state_q <= ST_ACK;
                if (state_q == ST_ADDR2 && nxt_d == ST_WRITE) begin
                  match10_q <= 1'b1;
                end
                if (push_d) begin
                  rx_wr_q <= '{valid: 1'b1, data: byte_in};
                end
                if (state_q == ST_GCMD) begin
                  if (byte_in == GC_SOFT_RST) begin
                    flush_q   <= 1'b1;
                    query_q   <= 1'b0;
                    match10_q <= 1'b0;
                  end else if (byte_in == GC_FLUSH) begin
                    flush_q <= 1'b1;
                  end else if (byte_in == GC_AVAIL) begin
                    query_q <= 1'b1;
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_drv_q) begin
                SDA_OE    <= ack_q;
                ack_drv_q <= 1'b1;
              end else begin
                ack_drv_q <= 1'b0;
                if (!ack_q) begin
                  SDA_OE  <= 1'b0;
                  state_q <= ST_IGNORE;
                end else if (nxt_q == ST_READ) begin
                  SDA_OE   <= !load_byte[7];
                  tx_sh_q  <= {load_byte[6:0], 1'b0};
                  tx_pop_q <= tx_valid && !query_q;
                  query_q  <= 1'b0;
                  cnt_q    <= 4'h1;
                  state_q  <= ST_READ;
                end else begin
                  SDA_OE  <= 1'b0;
                  state_q <= nxt_q;
                end
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (cnt_q == TX_BITS) begin
                SDA_OE  <= 1'b0;
                cnt_q   <= '0;
                state_q <= ST_MACK;
              end else begin
                SDA_OE  <= !tx_sh_q[7];
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                cnt_q   <= cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_q) begin
                state_q <= ST_IGNORE;
              end else begin
                cnt_q <= MACK_OK;
              end
            end else if (scl_fall && cnt_q == MACK_OK) begin
              SDA_OE   <= !load_byte[7];
              tx_sh_q  <= {load_byte[6:0], 1'b0};
              tx_pop_q <= tx_valid && !query_q;
              query_q  <= 1'b0;
              state_q  <= ST_READ;
            end
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // Host bytes arrive as a plain stream; line settings never reach this block.
  isb_fifo #(
    .W(BUF_WIDTH),
    .D(BUF_DEPTH)
  ) u_tx_fifo (
    .clk      (SYS_CLK),
    .rst_n    (rst_n),
    .clr      (flush_q),
    .wr_valid (HOST_TX_VALID),
    .wr_ready (tx_ready),
    .wr_data  (HOST_TX_DATA),
    .rd_valid (tx_valid),
    .rd_ready (tx_pop_q),
    .rd_data  (tx_data),
    .count    (tx_count)
  );

  assign HOST_TX_READY = tx_ready;

  isb_fifo #(
    .W(BUF_WIDTH),
    .D(BUF_DEPTH)
  ) u_rx_fifo (
    .clk      (SYS_CLK),
    .rst_n    (rst_n),
    .clr      (flush_q),
    .wr_valid (rx_wr_q.valid),
    .wr_ready (rx_room),
    .wr_data  (rx_wr_q.data),
    .rd_valid (rx_valid),
    .rd_ready (rx_pop),
    .rd_data  (rx_data),
    .count    ()
  );

  isb_lat_timer #(
    .CYCLES(LATENCY_CYCLES)
  ) u_lat_timer (
    .clk     (SYS_CLK),
    .rst_n   (rst_n),
    .restart (rx_wr_q.valid),
    .active  (rx_valid && !fwd_q),
    .expire  (lat_expire)
  );

  // Forwarding drains the whole buffer once started, so the host sees bursts.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fwd_q <= 1'b0;
    end else if (flush_q) begin
      fwd_q <= 1'b0;
    end else if (!rx_room || lat_expire) begin
      fwd_q <= 1'b1;
    end else if (!rx_valid) begin
      fwd_q <= 1'b0;
    end
  end

  assign rx_pop = fwd_q && rx_valid && (!HOST_RX_VALID || HOST_RX_READY) && !flush_q;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_RX_VALID <= 1'b0;
      HOST_RX_DATA  <= '0;
    end else if (flush_q) begin
      HOST_RX_VALID <= 1'b0;
    end else if (rx_pop) begin
      HOST_RX_VALID <= 1'b1;
      HOST_RX_DATA  <= rx_data;
    end else if (HOST_RX_READY) begin
      HOST_RX_VALID <= 1'b0;
    end
  end

endmodule

// ===== tb/isb_master_model.sv
/*
  Behavioural two-wire bus master that clocks the bridge.
  Assumes an external pull-up on the data line and a bench calling its tasks.
*/
`timescale 1ns/100ps
module isb_master_model #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_half();
    repeat (HALF) @(negedge clk);
  endtask
  // Data moves two cycles after the clock falls so the slave sees clean hold.
  task automatic xfer(input logic drive_low, output logic b);
    repeat (2) @(negedge clk);
    sda_low = drive_low;
    wait_half();
    scl = 1'b1;
    wait_half();
    b = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    repeat (2) @(negedge clk);
    sda_low = 1'b0;
    wait_half();
    scl = 1'b1;
    wait_half();
    sda_low = 1'b1;
    wait_half();
    scl = 1'b0;
  endtask
  // The clock stands high after a stop, so the bus is idle between frames.
  task automatic stop();
    repeat (2) @(negedge clk);
    sda_low = 1'b1;
    wait_half();
    scl = 1'b1;
    wait_half();
    sda_low = 1'b0;
    wait_half();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) xfer(!d[i], b);
    xfer(1'b0, b);
    ack = !b;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b0, b);
      d[i] = b;
    end
    xfer(!last, b);
  endtask
endmodule

// ===== tb/isb_monitor.sv
/*
  Port checker for the two-wire slave data bridge.
  Assumes it is bound to isb_top, whose reset and clock it shares.
*/
`timescale 1ns/100ps
module isb_monitor (
  input wire logic       SYS_CLK,
  input wire logic       ARST_N,
  input wire logic       SCL_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE,
  input wire logic       HOST_TX_VALID,
  input wire logic       HOST_TX_READY,
  input wire logic [7:0] HOST_RX_DATA,
  input wire logic       HOST_RX_VALID,
  input wire logic       HOST_RX_READY,
  input wire logic       CFG_WE,
  input wire logic       CFG_SERIAL_EN,
  input wire logic       SERIAL_LAYER_EN,
  input wire logic       TX_EMPTY_N,
  input wire logic       RX_FULL_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  // The data line may only move once the master clock has been low a full sample.
  a_oe_after_fall: assert property ($changed(SDA_OE) |-> !SCL_I && !$past(SCL_I))
    else $error("sda enable moved while scl high");
  a_open_drain: assert property (SDA_OE |-> !SDA_O)
    else $error("sda driven high");
  a_tx_fill: assert property (HOST_TX_VALID && HOST_TX_READY |-> ##[1:2] TX_EMPTY_N)
    else $error("host byte not shown as held");
  a_tx_room: assert property (!TX_EMPTY_N |-> ##[0:6] HOST_TX_READY)
    else $error("empty outgoing buffer refuses host byte");
  a_rx_hold: assert property (HOST_RX_VALID && !HOST_RX_READY |=>
    HOST_RX_VALID && $stable(HOST_RX_DATA))
    else $error("host byte dropped before taken");
  a_full_fwd: assert property (!RX_FULL_N && HOST_RX_READY |-> ##[0:4] HOST_RX_VALID)
    else $error("full incoming buffer not forwarded");
  a_serial_set: assert property (CFG_WE && CFG_SERIAL_EN |-> ##[1:2] SERIAL_LAYER_EN)
    else $error("serial option not set");
  a_serial_clr: assert property (CFG_WE && !CFG_SERIAL_EN |-> ##[1:2] !SERIAL_LAYER_EN)
    else $error("serial option not cleared");
  a_serial_hold: assert property (!CFG_WE && !$past(CFG_WE) && !$past(CFG_WE, 2) |->
    $stable(SERIAL_LAYER_EN))
    else $error("serial option moved without a write");

  c_ack: cover property ($rose(SDA_OE));
  c_rx_take: cover property (HOST_RX_VALID && HOST_RX_READY);
  c_full: cover property ($fell(RX_FULL_N));
endmodule

// ===== tb/isb_top_tb.sv
/*
  Self-checking bench for the bridge: host streams, bus master, config port.
  Assumes a shortened latency timer so forwarding is seen in a short run.
*/
`timescale 1ns/100ps
module isb_top_tb;
  import isb_pkg::*;
  localparam int unsigned LAT = 1000;
  logic       sys_clk, arst_n, scl, m_low, sda_o, sda_oe, ack, ser_en, tx_ne, rx_nf;
  logic       tx_valid, tx_ready, rx_valid, rx_ready, cfg_we, cfg_ten, cfg_ser;
  logic [7:0] tx_data, rx_data, rd;
  logic [9:0] cfg_addr;
  int         n_errors, n_tests, n;
  wire        sda = !((sda_oe && !sda_o) || m_low);

  always #5 sys_clk = ~sys_clk;

  isb_top #(.LATENCY_CYCLES(LAT)) i_dut (.SYS_CLK(sys_clk), .ARST_N(arst_n),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .HOST_TX_DATA(tx_data), .HOST_TX_VALID(tx_valid), .HOST_TX_READY(tx_ready),
    .HOST_RX_DATA(rx_data), .HOST_RX_VALID(rx_valid), .HOST_RX_READY(rx_ready),
    .CFG_WE(cfg_we), .CFG_TEN_BIT(cfg_ten), .CFG_ADDR(cfg_addr),
    .CFG_SERIAL_EN(cfg_ser), .SERIAL_LAYER_EN(ser_en), .TX_EMPTY_N(tx_ne),
    .RX_FULL_N(rx_nf));
  isb_master_model #(.HALF(8)) i_master (.clk(sys_clk), .sda(sda), .scl(scl),
    .sda_low(m_low));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic push(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (tx_ready !== 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    tx_data = b;
    tx_valid = 1'b1;
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask
  task automatic pop(input logic [7:0] exp, input int lim);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (rx_valid !== 1'b1 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    chk("rx_valid", 8'h01, rx_valid);
    chk("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    i_master.wbyte(b, ack);
    chk("ack", e, ack);
  endtask
  task automatic cfg(input logic ten, input logic [9:0] a, input logic s);
    cfg_ten = ten;
    cfg_addr = a;
    cfg_ser = s;
    cfg_we = 1'b1;
    @(negedge sys_clk);
    cfg_we = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("serial_en", s, ser_en);
  endtask

  task automatic t_reset();
    chk("serial_en", 8'h00, ser_en);
    chk("tx_ne", 8'h00, tx_ne);
    chk("rx_nf", 8'h01, rx_nf);
    chk("tx_ready", 8'h01, tx_ready);
  endtask
  task automatic t_tx_full();
    for (int i = 0; i < 16; i++) push(8'(i));
    chk("tx_full", 8'h00, tx_ready);
    i_master.start();
    wr(GEN_CALL, 1'b1);
    wr(GC_FLUSH, 1'b1);
    i_master.stop();
    chk("tx_flush", 8'h01, tx_ready);
    chk("tx_ne", 8'h00, tx_ne);
  endtask
  task automatic t_refuse();
    i_master.start();
    wr(8'h46, 1'b0);
    i_master.stop();
    i_master.start();
    wr(8'h45, 1'b0);
    i_master.stop();
  endtask
  task automatic t_read();
    logic [7:0] v [3] = '{8'hA5, 8'h3C, 8'h00};
    foreach (v[i]) push(v[i]);
    chk("tx_ne", 8'h01, tx_ne);
    i_master.start();
    wr(8'h45, 1'b1);
    foreach (v[i]) begin
      i_master.rbyte(i == 2, rd);
      chk("read", v[i], rd);
    end
    i_master.stop();
    chk("tx_ne", 8'h00, tx_ne);
  endtask
  task automatic t_write();
    i_master.start();
    wr(8'h44, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    i_master.stop();
    chk("rx_early", 8'h00, rx_valid);
    pop(8'h11, 3 * LAT);
    pop(8'h22, 100);
  endtask
  task automatic t_fill();
    n = 0;
    ack = 1'b1;
    i_master.start();
    wr(8'h44, 1'b1);
    for (int i = 0; i < 20 && ack; i++) begin
      i_master.wbyte(8'h40 + i, ack);
      if (ack) n++;
    end
    chk("fill_nack", 8'h00, ack);
    chk("fill_cnt", 8'h01, n == 16 || n == 17);
    i_master.stop();
    i_master.start();
    wr(8'h44, 1'b0);
    i_master.stop();
    for (int i = 0; i < n; i++) pop(8'h40 + i, 100);
    chk("rx_nf", 8'h01, rx_nf);
  endtask
  task automatic t_gcall();
    logic [7:0] c [2] = '{GC_FLUSH, GC_SOFT_RST};
    foreach (c[i]) push(8'h30 + i);
    i_master.start();
    wr(GEN_CALL, 1'b1);
    wr(GC_AVAIL, 1'b1);
    i_master.start();
    wr(8'h45, 1'b1);
    i_master.rbyte(1'b1, rd);
    i_master.stop();
    chk("avail", 8'h02, rd);
    foreach (c[i]) begin
      push(8'h55);
      i_master.start();
      wr(8'h44, 1'b1);
      wr(8'h77, 1'b1);
      i_master.start();
      wr(GEN_CALL, 1'b1);
      wr(c[i], 1'b1);
      i_master.stop();
      repeat (10) @(negedge sys_clk);
      chk("tx_ne", 8'h00, tx_ne);
      repeat (LAT + 100) @(negedge sys_clk);
      chk("rx_valid", 8'h00, rx_valid);
    end
  endtask
  task automatic t_ten_bit();
    cfg(1'b1, 10'h2A5, 1'b1);
    push(8'h6B);
    i_master.start();
    wr(8'h44, 1'b0);
    i_master.stop();
    i_master.start();
    wr(8'hF4, 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h5A, 1'b1);
    i_master.start();
    wr(8'hF5, 1'b1);
    i_master.rbyte(1'b1, rd);
    chk("read10", 8'h6B, rd);
    i_master.stop();
    pop(8'h5A, 3 * LAT);
    cfg(1'b0, 10'h022, 1'b0);
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    cfg_we = 1'b0;
    cfg_ten = 1'b0;
    cfg_addr = 10'h022;
    cfg_ser = 1'b0;
    n_errors = 0;
    n_tests = 0;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_reset();
    t_refuse();
    t_read();
    t_write();
    t_fill();
    t_gcall();
    t_tx_full();
    t_ten_bit();
    summarize();
  end
  // A hung handshake would otherwise stall the run forever.
  initial begin
    #800_000;
    n_errors++;
    summarize();
  end
endmodule

bind isb_top isb_monitor i_mon (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .HOST_TX_VALID(HOST_TX_VALID),
  .HOST_TX_READY(HOST_TX_READY), .HOST_RX_DATA(HOST_RX_DATA),
  .HOST_RX_VALID(HOST_RX_VALID), .HOST_RX_READY(HOST_RX_READY), .CFG_WE(CFG_WE),
  .CFG_SERIAL_EN(CFG_SERIAL_EN), .SERIAL_LAYER_EN(SERIAL_LAYER_EN),
  .TX_EMPTY_N(TX_EMPTY_N), .RX_FULL_N(RX_FULL_N));
